// *** logic/ulsmc_regs.sv ***
`timescale 1ns/1ns
module ulsmc_regs #(
  parameter int RX_DEPTH = 64
) (
  // Clock and resets
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_reset,
  input  wire logic                       i_soft_reset,
  // Register access from the host port
  input  wire ulsmc_pkg::ulsmc_reg_req_t  i_reg_req,
  output logic [7:0]                      o_reg_rdata,
  // Neighbouring register contents
  input  wire logic [7:0]                 i_line_ctrl,
  input  wire logic [7:0]                 i_enh_feature,
  input  wire logic [7:0]                 i_special_func,
  input  wire logic [7:0]                 i_io_ctrl,
  // Hardware flow control
  input  wire logic                       i_auto_rts_en,
  input  wire logic                       i_flow_rts_n,
  // Modem pins and loopback routing
  output logic                            o_rts_n,
  output logic                            o_dtr_n,
  output logic                            o_loopback,
  output ulsmc_pkg::ulsmc_loop_t          o_loop_status,
  output logic [7:0]                      o_modem_ctrl,
  // Receive path events
  input  wire logic                       i_rx_push,
  input  wire ulsmc_pkg::ulsmc_rx_err_t   i_rx_err,
  input  wire logic                       i_rx_pop,
  // Transmit path events
  input  wire logic                       i_thr_write,
  input  wire logic                       i_thr_to_tsr_last,
  input  wire logic                       i_tsr_busy,
  // Line status and flow-on characters
  output ulsmc_pkg::ulsmc_lsr_t           o_line_status,
  output logic [7:0]                      o_flow_on_first,
  output logic [7:0]                      o_flow_on_second
);

  localparam int AW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(RX_DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(RX_DEPTH - 1);

  // Enhanced bank is open for this line control and special function
  function automatic logic enh_bank(input logic [7:0] line_control_reg,
                                    input logic [7:0] special_function_reg);
    return (line_control_reg == ulsmc_pkg::LCR_ENHANCED) && !special_function_reg[ulsmc_pkg::SFR_ALT_BIT];
  endfunction : enh_bank

  // Any error tag on a byte
  function automatic logic any_err(input ulsmc_pkg::ulsmc_rx_err_t e);
    return e.brk || e.fe || e.pe;
  endfunction : any_err

  // Pointer advance with wrap for any depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  logic                      bank_enh;
  logic                      wr_on_first;
  logic                      wr_on_second;
  logic                      wr_mcr;
  logic                      rd_lsr;
  logic [7:0]                mcr_reg;
  logic [7:0]                mcr_next;
  logic [7:0]                mcr_wmask;
  logic [7:0]                on_first_reg;
  logic [7:0]                on_second_reg;
  logic                      loop_on;
  logic                      dtr_sel;
  logic                      rts_n_reg;
  logic                      dtr_n_reg;
  logic                      loopback_reg;
  ulsmc_pkg::ulsmc_loop_t    loop_reg;
  ulsmc_pkg::ulsmc_rx_err_t  err_mem [RX_DEPTH];
  logic [AW-1:0]             wr_ptr_reg;
  logic [AW-1:0]             rd_ptr_reg;
  logic [AW-1:0]             rd_ptr_next;
  logic [CW-1:0]             count_reg;
  logic [CW-1:0]             count_next;
  logic [CW-1:0]             err_cnt_reg;
  logic [CW-1:0]             err_cnt_next;
  logic                      push_ok;
  logic                      pop_ok;
  logic                      rx_full;
  ulsmc_pkg::ulsmc_rx_err_t  head_reg;
  ulsmc_pkg::ulsmc_rx_err_t  head_next;
  logic                      dr_reg;
  logic                      fifo_err_reg;
  logic                      oe_reg;
  logic                      thre_reg;
  logic                      thre_next;
  logic                      temt_reg;
  logic [7:0]                rdata_reg;

  // Address decode; line status hides behind the divisor latch bit
  assign bank_enh     = enh_bank(i_line_ctrl, i_special_func);
  assign wr_on_first  = i_reg_req.wr && bank_enh &&
                        (i_reg_req.addr == ulsmc_pkg::OFS_FLOW_ON_FIRST);
  assign wr_on_second = i_reg_req.wr && bank_enh &&
                        (i_reg_req.addr == ulsmc_pkg::OFS_FLOW_ON_SECOND);
  assign wr_mcr       = i_reg_req.wr && !bank_enh &&
                        (i_reg_req.addr == ulsmc_pkg::OFS_MODEM_CTRL);
  assign rd_lsr       = i_reg_req.rd && !bank_enh &&
                        !i_line_ctrl[ulsmc_pkg::LCR_DIVISOR_BIT] &&
                        (i_reg_req.addr == ulsmc_pkg::OFS_LINE_STATUS);

  // Protected bits keep their value unless the enhanced enable is set
  always_comb
  begin
    mcr_wmask = i_enh_feature[ulsmc_pkg::EFR_ENHANCE_BIT] ? 8'hff
                : ~ulsmc_pkg::MCR_PROT_MASK;
    mcr_next  = (i_reg_req.wdata & mcr_wmask) | (mcr_reg & ~mcr_wmask);
  end

  // Modem control register; software reset clears it too
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_soft_reset)
      mcr_reg <= ulsmc_pkg::RST_MODEM_CTRL;
    else if (wr_mcr)
      mcr_reg <= mcr_next;
  end

  // Flow-on characters survive software reset by design
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      on_first_reg  <= ulsmc_pkg::RST_FLOW_ON;
      on_second_reg <= ulsmc_pkg::RST_FLOW_ON;
    end
    else
    begin
      if (wr_on_first)
        on_first_reg <= i_reg_req.wdata;
      if (wr_on_second)
        on_second_reg <= i_reg_req.wdata;
    end
  end

  assign loop_on = mcr_reg[ulsmc_pkg::MCR_LOOP_BIT];
  assign dtr_sel = i_io_ctrl[ulsmc_pkg::IOC_DTR_PIN5_BIT] ||
                   i_io_ctrl[ulsmc_pkg::IOC_DTR_PIN1_BIT];

  // Pin drive; in loopback the pins park inactive high
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_soft_reset)
    begin
      rts_n_reg    <= 1'b1;
      dtr_n_reg    <= 1'b1;
      loopback_reg <= 1'b0;
      loop_reg     <= '0;
    end
    else
    begin
      if (loop_on)
        rts_n_reg <= 1'b1;
      else if (i_auto_rts_en)
        rts_n_reg <= i_flow_rts_n;
      else
        rts_n_reg <= !mcr_reg[ulsmc_pkg::MCR_RTS_BIT];
      dtr_n_reg    <= (loop_on || !dtr_sel) ? 1'b1
                      : !mcr_reg[ulsmc_pkg::MCR_DTR_BIT];
      loopback_reg <= loop_on;
      loop_reg.cts <= loop_on && mcr_reg[ulsmc_pkg::MCR_RTS_BIT];
      loop_reg.dsr <= loop_on && mcr_reg[ulsmc_pkg::MCR_DTR_BIT];
      loop_reg.ri  <= loop_on && mcr_reg[ulsmc_pkg::MCR_OUT1_BIT];
      loop_reg.cd  <= loop_on && mcr_reg[ulsmc_pkg::MCR_OUT2_BIT];
    end
  end

  // Receive FIFO tracking; a full FIFO refuses the new byte
  assign rx_full = (count_reg == FULL_CNT);
  assign push_ok = i_rx_push && !rx_full;
  assign pop_ok  = i_rx_pop && (count_reg != '0);

  // Tag storage; no reset needed since the count gates every read
  always_ff @(posedge i_clk_sys)
  begin
    if (push_ok)
      err_mem[wr_ptr_reg] <= i_rx_err;
  end

  // Next count, errored-byte count and head tags
  always_comb
  begin
    rd_ptr_next  = pop_ok ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next   = count_reg;
    err_cnt_next = err_cnt_reg;
    if (push_ok && !pop_ok)
      count_next = CW'(count_reg + 1'b1);
    else if (pop_ok && !push_ok)
      count_next = CW'(count_reg - 1'b1);
    if (push_ok && any_err(i_rx_err))
      err_cnt_next = CW'(err_cnt_next + 1'b1);
    if (pop_ok && any_err(err_mem[rd_ptr_reg]))
      err_cnt_next = CW'(err_cnt_next - 1'b1);
    // A byte landing in an empty FIFO is not in storage yet
    if (push_ok && (count_next == CW'(1)) && (count_reg != CW'(1) || pop_ok))
      head_next = i_rx_err;
    else if (count_next != '0)
      head_next = err_mem[rd_ptr_next];
    else
      head_next = '0;
  end

  // Receive pointers, counts and derived status flops
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_soft_reset)
    begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      err_cnt_reg  <= '0;
      head_reg     <= '0;
      dr_reg       <= 1'b0;
      fifo_err_reg <= 1'b0;
    end
    else
    begin
      if (push_ok)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      rd_ptr_reg   <= rd_ptr_next;
      count_reg    <= count_next;
      err_cnt_reg  <= err_cnt_next;
      head_reg     <= head_next;
      dr_reg       <= (count_next != '0);
      fifo_err_reg <= (err_cnt_next != '0);
    end
  end

  // Overrun: set wins over the read that clears it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_soft_reset)
      oe_reg <= 1'b0;
    else if (i_rx_push && rx_full)
      oe_reg <= 1'b1;
    else if (rd_lsr)
      oe_reg <= 1'b0;
  end

  // Holding empty: the move of the last byte wins over a new write
  always_comb
  begin
    if (i_thr_to_tsr_last)
      thre_next = 1'b1;
    else if (i_thr_write)
      thre_next = 1'b0;
    else
      thre_next = thre_reg;
  end

  // Transmit flags; both come up set after reset
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || i_soft_reset)
    begin
      thre_reg <= ulsmc_pkg::RST_LINE_STATUS[5];
      temt_reg <= ulsmc_pkg::RST_LINE_STATUS[6];
    end
    else
    begin
      thre_reg <= thre_next;
      temt_reg <= thre_next && !i_tsr_busy && !i_thr_write;
    end
  end

  // Read data; unmapped or hidden registers read as zero
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      rdata_reg <= 8'h00;
    else if (i_reg_req.rd)
    begin
      if (bank_enh && i_reg_req.addr == ulsmc_pkg::OFS_FLOW_ON_FIRST)
        rdata_reg <= on_first_reg;
      else if (bank_enh && i_reg_req.addr == ulsmc_pkg::OFS_FLOW_ON_SECOND)
        rdata_reg <= on_second_reg;
      else if (!bank_enh && i_reg_req.addr == ulsmc_pkg::OFS_MODEM_CTRL)
        rdata_reg <= mcr_reg;
      else if (rd_lsr)
        rdata_reg <= o_line_status;
      else
        rdata_reg <= 8'h00;
    end
  end

  // Outputs straight from flops
  assign o_reg_rdata      = rdata_reg;
  assign o_rts_n          = rts_n_reg;
  assign o_dtr_n          = dtr_n_reg;
  assign o_loopback       = loopback_reg;
  assign o_loop_status    = loop_reg;
  assign o_modem_ctrl     = mcr_reg;
  assign o_flow_on_first  = on_first_reg;
  assign o_flow_on_second = on_second_reg;
  assign o_line_status    = '{fifo_err: fifo_err_reg, temt: temt_reg,
                              thre: thre_reg, brk: head_reg.brk,
                              fe: head_reg.fe, pe: head_reg.pe,
                              oe: oe_reg, dr: dr_reg};

  // Checks
  property p_loop_cts;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    loop_on && !wr_mcr |=> o_loop_status.cts == $past(mcr_reg[1]);
  endproperty
  a_loop_cts: assert property (p_loop_cts)
    else $error("loopback cts does not follow rts bit");

  property p_loop_dsr;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    loop_on |=> o_loop_status.dsr == $past(mcr_reg[0]) && o_loopback;
  endproperty
  a_loop_dsr: assert property (p_loop_dsr)
    else $error("loopback dsr does not follow dtr bit");

  property p_auto_rts;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    i_auto_rts_en && !loop_on |=> o_rts_n == $past(i_flow_rts_n);
  endproperty
  a_auto_rts: assert property (p_auto_rts)
    else $error("rts pin not driven by flow control");

  property p_dtr_force;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    dtr_sel && !loop_on |=> o_dtr_n != $past(mcr_reg[0]);
  endproperty
  a_dtr_force: assert property (p_dtr_force)
    else $error("dtr pin level wrong for control bit");

  property p_mcr_protect;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    !i_enh_feature[4] |=> (mcr_reg & 8'hec) == ($past(mcr_reg) & 8'hec);
  endproperty
  a_mcr_protect: assert property (p_mcr_protect)
    else $error("protected modem control bits changed");

  property p_on_char_keep;
    @(posedge i_clk_sys) disable iff (i_reset)
    !wr_on_first |=> on_first_reg == $past(on_first_reg);
  endproperty
  a_on_char_keep: assert property (p_on_char_keep)
    else $error("on character changed without a write");

  property p_overrun;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    i_rx_push && rx_full |=> o_line_status.oe && count_reg != '0;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun missed or byte stored while full");

  property p_ready;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    push_ok |=> o_line_status.dr;
  endproperty
  a_ready: assert property (p_ready)
    else $error("data ready not set after a stored byte");

  property p_temt;
    @(posedge i_clk_sys) disable iff (i_reset || i_soft_reset)
    i_thr_write || i_tsr_busy |=> !o_line_status.temt;
  endproperty
  a_temt: assert property (p_temt)
    else $error("transmitter empty while a character is held");

endmodule : ulsmc_regs

// *** common/ulsmc_pkg.sv ***
package ulsmc_pkg;

  // Register offsets inside the channel map
  localparam logic [2:0] OFS_FLOW_ON_FIRST  = 3'h4;
  localparam logic [2:0] OFS_MODEM_CTRL     = 3'h4;
  localparam logic [2:0] OFS_LINE_STATUS    = 3'h5;
  localparam logic [2:0] OFS_FLOW_ON_SECOND = 3'h5;

  // Values after reset
  localparam logic [7:0] RST_LINE_STATUS = 8'h60;
  localparam logic [7:0] RST_FLOW_ON     = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL  = 8'h00;

  // Line control value that opens the enhanced bank
  localparam logic [7:0] LCR_ENHANCED = 8'hbf;

  // Field positions in neighbouring registers
  localparam int LCR_DIVISOR_BIT  = 7;
  localparam int SFR_ALT_BIT      = 2;
  localparam int EFR_ENHANCE_BIT  = 4;
  localparam int IOC_DTR_PIN5_BIT = 1;
  localparam int IOC_DTR_PIN1_BIT = 2;

  // Modem control fields
  localparam int MCR_DTR_BIT  = 0;
  localparam int MCR_RTS_BIT  = 1;
  localparam int MCR_OUT1_BIT = 2;
  localparam int MCR_OUT2_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  // Bits 7:5 and 3:2 need the enhanced enable to change
  localparam logic [7:0] MCR_PROT_MASK = 8'hec;

  // Register access request from the serial host port
  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ulsmc_reg_req_t;

  // Error tags carried by each received byte
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
  } ulsmc_rx_err_t;

  // Line status layout, bit 7 down to bit 0
  typedef struct packed {
    logic fifo_err;
    logic temt;
    logic thre;
    logic brk;
    logic fe;
    logic pe;
    logic oe;
    logic dr;
  } ulsmc_lsr_t;

  // Loopback routing into the modem status bits
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ulsmc_loop_t;

endpackage : ulsmc_pkg

// *** tb/ulsmc_host.sv ***
`timescale 1ns/1ns
// Host side of the serial port: single register accesses, one at a time
module ulsmc_host (
  // Clock
  input  wire logic                  i_clk_sys,
  // Register access toward the channel
  output ulsmc_pkg::ulsmc_reg_req_t  o_reg_req
);
  // Bus idle until the first access
  initial o_reg_req = '0;

  // One-cycle strobe; address and data scrambled once released
  task automatic access(input logic w, input logic r,
                        input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_reg_req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge i_clk_sys);
    o_reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : access
endmodule : ulsmc_host

// *** tb/test_uart_line_status_modem_ctrl.sv ***
`timescale 1ns/1ns
module test_uart_line_status_modem_ctrl;
  localparam int DEPTH = 4;
  // Design connections
  logic i_clk_sys, i_reset, i_soft_reset;
  ulsmc_pkg::ulsmc_reg_req_t req;
  logic [7:0] o_reg_rdata, i_line_ctrl, i_enh_feature;
  logic [7:0] i_special_func, i_io_ctrl, o_modem_ctrl;
  logic [7:0] o_flow_on_first, o_flow_on_second;
  logic i_auto_rts_en, i_flow_rts_n, o_rts_n, o_dtr_n, o_loopback;
  logic i_rx_push, i_rx_pop, i_thr_write, i_thr_to_tsr_last, i_tsr_busy;
  ulsmc_pkg::ulsmc_loop_t o_loop_status;
  ulsmc_pkg::ulsmc_rx_err_t i_rx_err;
  ulsmc_pkg::ulsmc_lsr_t o_line_status;
  // Reference model state
  logic [2:0] rxq[$];
  logic [7:0] lsr_m, mcr_m, on1_m, on2_m, rd_m, lsr_o, mcr_o, seed, r1, r2;
  logic [3:0] lps_m;
  logic rts_m, dtr_m, lp_m, run, enh, full, oe, thre, ferr;
  int error_cnt, num_checks;

  ulsmc_regs #(.RX_DEPTH(DEPTH)) ulsmc_regs_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
    .i_reg_req(req), .o_reg_rdata(o_reg_rdata),
    .i_line_ctrl(i_line_ctrl), .i_enh_feature(i_enh_feature),
    .i_special_func(i_special_func), .i_io_ctrl(i_io_ctrl),
    .i_auto_rts_en(i_auto_rts_en), .i_flow_rts_n(i_flow_rts_n),
    .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_loopback(o_loopback),
    .o_loop_status(o_loop_status), .o_modem_ctrl(o_modem_ctrl),
    .i_rx_push(i_rx_push), .i_rx_err(i_rx_err), .i_rx_pop(i_rx_pop),
    .i_thr_write(i_thr_write), .i_thr_to_tsr_last(i_thr_to_tsr_last),
    .i_tsr_busy(i_tsr_busy), .o_line_status(o_line_status),
    .o_flow_on_first(o_flow_on_first), .o_flow_on_second(o_flow_on_second));

  ulsmc_host ulsmc_host_i (.i_clk_sys(i_clk_sys), .o_reg_req(req));

  // 10 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Pseudo-random byte source
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Model: every registered output follows from the values held before
  always @(posedge i_clk_sys)
  begin
    full = (rxq.size() == DEPTH);
    lsr_o = lsr_m;
    mcr_o = mcr_m;
    enh = i_line_ctrl == 8'hbf && !i_special_func[2];
    // Reads still land during a software reset, from the old contents
    if (req.rd && !i_reset)
      rd_m = enh ? (req.addr == 3'h4 ? on1_m : req.addr == 3'h5 ? on2_m
              : 8'h00) : req.addr == 3'h4 ? mcr_o
              : (req.addr == 3'h5 && !i_line_ctrl[7]) ? lsr_o : 8'h00;
    if (i_reset || i_soft_reset)
    begin
      rxq.delete();
      {mcr_m, lsr_m, rts_m, dtr_m, lp_m, lps_m} = {8'h00, 8'h60, 7'h60};
      if (i_reset)
        {on1_m, on2_m, rd_m} = 24'h000000;
    end
    else
    begin
      if (req.wr && enh && req.addr == 3'h4)
        on1_m = req.wdata;
      if (req.wr && enh && req.addr == 3'h5)
        on2_m = req.wdata;
      if (req.wr && !enh && req.addr == 3'h4)
        mcr_m = i_enh_feature[4] ? req.wdata
                : (mcr_o & 8'hec) | (req.wdata & 8'h13);
      // A line status read clears overrun; a new overrun wins
      oe = lsr_o[1] && !(req.rd && !enh && req.addr == 3'h5
           && !i_line_ctrl[7]);
      if (i_rx_pop && rxq.size() > 0)
        void'(rxq.pop_front());
      if (i_rx_push && full)
        oe = 1'b1;
      else if (i_rx_push)
        rxq.push_back(i_rx_err);
      thre = i_thr_to_tsr_last ? 1'b1 : i_thr_write ? 1'b0 : lsr_o[5];
      ferr = 1'b0;
      foreach (rxq[k])
        ferr |= |rxq[k];
      lsr_m = {ferr, thre && !i_tsr_busy && !i_thr_write, thre,
               rxq.size() > 0 ? rxq[0] : 3'b000, oe, rxq.size() > 0};
      lp_m = mcr_o[4];
      lps_m = mcr_o[4] ? {mcr_o[3], mcr_o[2], mcr_o[0], mcr_o[1]} : 4'h0;
      rts_m = mcr_o[4] || (i_auto_rts_en ? i_flow_rts_n : !mcr_o[1]);
      dtr_m = mcr_o[4] || !(i_io_ctrl[1] | i_io_ctrl[2]) || !mcr_o[0];
    end
  end

  // Compare at the falling edge, well clear of updates
  always @(negedge i_clk_sys)
    if (run)
    begin
      chk(o_line_status, lsr_m, "lsr");
      chk(o_modem_ctrl, mcr_m, "mcr");
      chk(o_flow_on_first, on1_m, "on1");
      chk(o_flow_on_second, on2_m, "on2");
      chk(o_reg_rdata, rd_m, "rdata");
      chk({o_rts_n, o_dtr_n}, {rts_m, dtr_m}, "pins");
      chk({o_loopback, o_loop_status}, {lp_m, lps_m}, "loop");
    end

  // Watchdog well beyond the expected run
  initial
  begin
    #(4000 * 100);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    {i_reset, run, seed} = {2'b10, 8'h30};
    {i_soft_reset, i_line_ctrl, i_enh_feature, i_special_func} = '0;
    {i_io_ctrl, i_auto_rts_en, i_flow_rts_n, i_rx_push, i_rx_pop} = '0;
    {i_rx_err, i_thr_write, i_thr_to_tsr_last, i_tsr_busy} = '0;
    repeat (12) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    run <= 1'b1;
    // Reset value, then the on-characters in the enhanced bank
    ulsmc_host_i.access(1'b0, 1'b1, 3'h5, 8'h77);
    i_line_ctrl <= 8'hbf;
    ulsmc_host_i.access(1'b1, 1'b0, 3'h4, 8'ha5);
    ulsmc_host_i.access(1'b1, 1'b0, 3'h5, 8'h3c);
    ulsmc_host_i.access(1'b0, 1'b1, 3'h4, 8'h00);
    ulsmc_host_i.access(1'b0, 1'b1, 3'h3, 8'h00);
    i_special_func <= 8'h04;
    ulsmc_host_i.access(1'b0, 1'b1, 3'h5, 8'h00);
    ulsmc_host_i.access(1'b1, 1'b0, 3'h4, 8'hff);
    i_special_func <= 8'h00;
    i_line_ctrl <= 8'h00;
    ulsmc_host_i.access(1'b1, 1'b0, 3'h5, 8'hff);
    // Random traffic; soft reset midway keeps the on-characters
    for (int n = 0; n < 600; n++)
    begin
      seed = lfsr_next(seed);
      r1 = seed;
      seed = lfsr_next(seed);
      r2 = seed;
      i_soft_reset <= (n == 300);
      i_rx_push <= (n % 200 < 100) ? r1[0] | r1[1] : r1[0] & r1[1];
      i_rx_pop <= (n % 200 < 100) ? r1[2] & r1[3] : r1[2] | r1[3];
      i_rx_err <= r1[6:4] & {3{r1[7]}};
      i_thr_write <= r2[0] & r2[1];
      i_thr_to_tsr_last <= r2[2] & r2[3];
      i_tsr_busy <= r2[4] | (r2[2] & r2[3]);
      i_auto_rts_en <= r2[5];
      i_flow_rts_n <= r2[6];
      i_io_ctrl <= {5'h00, r1[1], r2[7], 1'b0};
      i_enh_feature <= {3'h0, r2[1], 4'h0};
      seed = lfsr_next(seed);
      if (r1[5:4] == 2'b00)
        ulsmc_host_i.access(1'b1, 1'b0, 3'h4, seed);
      else if (r1[5:4] == 2'b01)
        ulsmc_host_i.access(1'b0, 1'b1, 3'h5, seed);
      else
        @(posedge i_clk_sys);
    end
    complete_run();
  end
endmodule : test_uart_line_status_modem_ctrl
